// File: src/pdmr_ctrl.sv
`timescale 1ns/1ps
module pdmr_ctrl (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire pdmr_pkg::pdmr_req_s req,
	output logic req_ready,
	output logic req_taken,
	output logic powered_down,
	output logic boot_clock_ok,
	output pdmr_pkg::pdmr_pins_s pins
);
	typedef enum logic [1:0] {
		PDMR_ACTIVE = 2'b00,
		PDMR_ENTERING = 2'b01,
		PDMR_DOWN = 2'b11,
		PDMR_EXITING = 2'b10
	} pdmr_state_e;
	pdmr_state_e state_ff, nxt_state;
	pdmr_pkg::pdmr_cnt_t pulse_ff, nxt_pulse;
	pdmr_pkg::pdmr_cnt_t cmd_ff, nxt_cmd;
	pdmr_pkg::pdmr_cnt_t hold_ff, nxt_hold;
	pdmr_pkg::pdmr_cnt_t mrw_ff, nxt_mrw;
	pdmr_pkg::pdmr_cnt_t mrd_ff, nxt_mrd;
	pdmr_pkg::pdmr_cnt_t xp_ff, nxt_xp;
	pdmr_pkg::pdmr_cnt_t mrr_ff, nxt_mrr;
	pdmr_pkg::pdmr_cnt_t csh_ff, nxt_csh;
	pdmr_pkg::pdmr_cnt_t low_hold_ff, nxt_low_hold;
	pdmr_pkg::pdmr_pins_s pins_ff, nxt_pins;
	logic taken_ff, nxt_taken;
	logic ready_ff, nxt_ready;
	logic pd_ff, nxt_pd;
	logic go;
	function automatic pdmr_pkg::pdmr_cnt_t ld(input int n);
		return pdmr_pkg::pdmr_cnt_t'(n);
	endfunction
	function automatic pdmr_pkg::pdmr_cnt_t dec(input pdmr_pkg::pdmr_cnt_t c);
		return (c != '0) ? c - 1'b1 : c;
	endfunction
	function automatic pdmr_pkg::pdmr_cnt_t mx(input pdmr_pkg::pdmr_cnt_t a, input pdmr_pkg::pdmr_cnt_t b);
		return (a > b) ? a : b;
	endfunction
	// Readiness per op; a zero counter means its delay fully expired
	function automatic logic allowed(input pdmr_pkg::pdmr_op_e op, input pdmr_state_e st,
			input pdmr_pkg::pdmr_cnt_t c_cmd, input pdmr_pkg::pdmr_cnt_t c_pulse,
			input pdmr_pkg::pdmr_cnt_t c_mrw, input pdmr_pkg::pdmr_cnt_t c_mrd,
			input pdmr_pkg::pdmr_cnt_t c_xp, input pdmr_pkg::pdmr_cnt_t c_mrr,
			input pdmr_pkg::pdmr_cnt_t c_hold, input pdmr_pkg::pdmr_cnt_t c_csh);
		logic ok;
		ok = 1'b0;
		unique case (op)
			pdmr_pkg::PDMR_OP_CMD, pdmr_pkg::PDMR_OP_ZQ:
				ok = (st == PDMR_ACTIVE) && (c_xp == '0) && (c_mrd == '0); // [RULE7] [RULE12] [RULE16]
			pdmr_pkg::PDMR_OP_MRW:
				ok = (st == PDMR_ACTIVE) && (c_xp == '0) && (c_mrw == '0) && (c_mrd == '0); // [RULE11] [RULE16]
			pdmr_pkg::PDMR_OP_MRR:
				ok = (st == PDMR_ACTIVE) && (c_mrr == '0) && (c_mrd == '0); // [RULE13] [RULE16]
			pdmr_pkg::PDMR_OP_PD_ENTER:
				ok = (st == PDMR_ACTIVE) && (c_cmd == '0) && (c_pulse == '0) && (c_csh == '0); // [RULE2] [RULE3] [RULE8]
			pdmr_pkg::PDMR_OP_PD_EXIT:
				ok = (st == PDMR_DOWN) && (c_hold == '0) && (c_pulse == '0); // [RULE2] [RULE4] [RULE9] [RULE10]
			default:
				ok = 1'b0;
		endcase
		return ok;
	endfunction
	always_comb begin
		nxt_state = state_ff;
		nxt_pulse = dec(pulse_ff);
		nxt_cmd = dec(cmd_ff);
		nxt_hold = dec(hold_ff);
		nxt_mrw = dec(mrw_ff);
		nxt_mrd = dec(mrd_ff);
		nxt_xp = dec(xp_ff);
		nxt_mrr = dec(mrr_ff);
		nxt_csh = dec(csh_ff);
		nxt_low_hold = low_hold_ff;
		nxt_pins = pins_ff;
		nxt_pins.ca = 6'h00;
		nxt_pins.cs = 1'b0;
		nxt_taken = 1'b0;
		go = req.valid && ready_ff && allowed(req.op, state_ff, cmd_ff, pulse_ff, mrw_ff, mrd_ff, xp_ff,
			mrr_ff, hold_ff, csh_ff);
		if (go) begin
			nxt_taken = 1'b1;
			unique case (req.op)
				pdmr_pkg::PDMR_OP_CMD, pdmr_pkg::PDMR_OP_MRR: begin
					nxt_pins.cs = 1'b1;
					nxt_pins.ca = req.ca;
					nxt_cmd = ld(pdmr_pkg::CMD_TO_CLK_EN_LOW_CYC); // [RULE3] [RULE15]
					nxt_low_hold = mx(low_hold_ff, ld(pdmr_pkg::CLOCK_HOLD_AFTER_EN_LOW_CYC));
				end
				pdmr_pkg::PDMR_OP_MRW: begin
					nxt_pins.cs = 1'b1;
					nxt_pins.ca = req.ca;
					nxt_cmd = ld(pdmr_pkg::CMD_TO_CLK_EN_LOW_CYC);
					nxt_mrw = ld(pdmr_pkg::MODEWRITE_CMD_PERIOD_CYC); // [RULE11]
					nxt_mrd = ld(pdmr_pkg::MODE_SET_CMD_DELAY_CYC); // [RULE12]
					nxt_low_hold = ld(pdmr_pkg::MODEWRITE_TO_EN_LOW_HOLD_CYC); // [RULE9]
				end
				pdmr_pkg::PDMR_OP_ZQ: begin
					nxt_pins.cs = 1'b1;
					nxt_pins.ca = req.ca;
					nxt_cmd = ld(pdmr_pkg::CMD_TO_CLK_EN_LOW_CYC);
					nxt_low_hold = mx(low_hold_ff, ld(pdmr_pkg::CALIB_START_TO_EN_LOW_HOLD_CYC)); // [RULE10]
				end
				pdmr_pkg::PDMR_OP_PD_ENTER: begin
					// Chip select already parked low one cycle, covering its setup
					nxt_state = PDMR_ENTERING; // [RULE5]
				end
				pdmr_pkg::PDMR_OP_PD_EXIT: begin
					nxt_state = PDMR_EXITING;
					nxt_pins.clk_run = 1'b1;
					nxt_hold = ld(pdmr_pkg::CLOCK_VALID_BEFORE_EN_HIGH_CYC); // [RULE6]
				end
				default: begin
				end
			endcase
		end
		unique case (state_ff)
			PDMR_ACTIVE: begin
			end
			PDMR_ENTERING: begin
				nxt_pins.cke = 1'b0;
				nxt_pulse = ld(pdmr_pkg::CLK_EN_MIN_PULSE_CYC); // [RULE2]
				nxt_hold = mx(low_hold_ff, ld(pdmr_pkg::CLOCK_HOLD_AFTER_EN_LOW_CYC)); // [RULE4] [RULE9] [RULE1]
				nxt_low_hold = '0;
				nxt_state = PDMR_DOWN;
			end
			PDMR_DOWN: begin
				// Clock may stop only after the low-side hold has run out
				if (hold_ff == '0 && !go)
					nxt_pins.clk_run = 1'b0; // [RULE4]
			end
			PDMR_EXITING: begin
				if (hold_ff == '0) begin
					nxt_pins.cke = 1'b1;
					nxt_pulse = ld(pdmr_pkg::CLK_EN_MIN_PULSE_CYC); // [RULE2]
					nxt_xp = ld(pdmr_pkg::POWERDOWN_EXIT_DELAY_CYC); // [RULE7]
					nxt_mrr = ld(pdmr_pkg::POWERDOWN_EXIT_DELAY_CYC + pdmr_pkg::EXTRA_DELAY_BEFORE_MODE_READ_CYC); // [RULE13]
					nxt_csh = ld(pdmr_pkg::CHIPSEL_HOLD_AFTER_EN_HIGH_CYC); // [RULE8] [RULE5]
					nxt_state = PDMR_ACTIVE;
				end
			end
		endcase
		nxt_ready = (nxt_state == PDMR_ACTIVE) || (nxt_state == PDMR_DOWN);
		nxt_pd = (nxt_state != PDMR_ACTIVE);
	end
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff <= PDMR_ACTIVE;
			pulse_ff <= ld(pdmr_pkg::CLK_EN_MIN_PULSE_CYC);
			cmd_ff <= '0;
			hold_ff <= '0;
			mrw_ff <= '0;
			mrd_ff <= '0;
			xp_ff <= ld(pdmr_pkg::POWERDOWN_EXIT_DELAY_CYC);
			mrr_ff <= ld(pdmr_pkg::POWERDOWN_EXIT_DELAY_CYC + pdmr_pkg::EXTRA_DELAY_BEFORE_MODE_READ_CYC);
			csh_ff <= ld(pdmr_pkg::CHIPSEL_HOLD_AFTER_EN_HIGH_CYC);
			low_hold_ff <= '0;
			pins_ff <= '{cke: 1'b1, cs: 1'b0, clk_run: 1'b1, ca: 6'h00};
			taken_ff <= 1'b0;
			ready_ff <= 1'b0;
			pd_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			pulse_ff <= nxt_pulse;
			cmd_ff <= nxt_cmd;
			hold_ff <= nxt_hold;
			mrw_ff <= nxt_mrw;
			mrd_ff <= nxt_mrd;
			xp_ff <= nxt_xp;
			mrr_ff <= nxt_mrr;
			csh_ff <= nxt_csh;
			low_hold_ff <= nxt_low_hold;
			pins_ff <= nxt_pins;
			taken_ff <= nxt_taken;
			ready_ff <= nxt_ready;
			pd_ff <= nxt_pd;
		end
	end
	// Fixed by the build clock; 100 ns is inside the boot range
	logic boot_ok_ff;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			boot_ok_ff <= 1'b0;
		else
			boot_ok_ff <= (pdmr_pkg::BOOT_CLOCK_OK != 0); // [RULE14]
	end
	assign req_ready = ready_ff;
	assign req_taken = taken_ff;
	assign powered_down = pd_ff;
	assign boot_clock_ok = boot_ok_ff;
	assign pins = pins_ff;
endmodule

// File: src/pdmr_pkg.sv
// Overview of operation
// RULE1: A delay expires only when both its nanosecond and cycle minimums are met.
// RULE2: Hold clock enable at each level at least max(7.5 ns, 4 cycles).
// RULE3: Wait max(1.75 ns, 3 cycles) after last command before dropping clock enable.
// RULE4: Keep clock and chip select valid max(5 ns, 5 cycles) after enable falls.
// RULE5: Chip select valid at least 1.75 ns before enable falls or rises.
// RULE6: Run clock max(1.75 ns, 3 cycles) before raising enable to exit power-down.
// RULE7: Wait max(7.5 ns, 5 cycles) after power-down exit before next command.
// RULE8: Keep chip select valid max(7.5 ns, 5 cycles) after enable rises.
// RULE9: After mode write, keep clock and select valid max(14 ns, 10 cycles) past enable low.
// RULE10: After calibration start, keep clock and select valid max(1.75 ns, 3 cycles).
// RULE11: Space consecutive mode writes by max(10 ns, 10 cycles).
// RULE12: After a mode set, wait max(14 ns, 10 cycles) before a dependent command.
// RULE13: Mode read only after exit delay plus row-to-column delay plus 3 cycles.
// RULE14: Boot clock runs 10 to 55 MHz, cycle time at least 18 ns.
// RULE15: Each delay is a counter loaded with max of cycle count and rounded ns.
// RULE16: Block commands until their timer expires; track timers independently.
package pdmr_pkg;
	localparam int CLK_PERIOD_PS = 100000;
	// Times in picoseconds, figures as printed
	localparam int CLK_EN_MIN_PULSE_PS = 7500;
	localparam int CMD_TO_CLK_EN_LOW_PS = 1750;
	localparam int CLOCK_HOLD_AFTER_EN_LOW_PS = 5000;
	localparam int CHIPSEL_SETUP_PS = 1750;
	localparam int CLOCK_VALID_BEFORE_EN_HIGH_PS = 1750;
	localparam int POWERDOWN_EXIT_DELAY_PS = 7500;
	localparam int CHIPSEL_HOLD_AFTER_EN_HIGH_PS = 7500;
	localparam int MODEWRITE_TO_EN_LOW_HOLD_PS = 14000;
	localparam int CALIB_START_TO_EN_LOW_HOLD_PS = 1750;
	localparam int MODEWRITE_CMD_PERIOD_PS = 10000;
	localparam int MODE_SET_CMD_DELAY_PS = 14000;
	localparam int ROW_TO_COL_MIN_PS = 18000;
	localparam int BOOT_CLOCK_PERIOD_MIN_PS = 18000;
	localparam int BOOT_CLOCK_PERIOD_MAX_PS = 100000;
	function automatic int cyc(input int ps, input int nck);
		int c;
		c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		if (c < 1) c = 1;
		return (c > nck) ? c : nck;
	endfunction
	localparam int CLK_EN_MIN_PULSE_CYC = cyc(CLK_EN_MIN_PULSE_PS, 4);
	localparam int CMD_TO_CLK_EN_LOW_CYC = cyc(CMD_TO_CLK_EN_LOW_PS, 3);
	localparam int CLOCK_HOLD_AFTER_EN_LOW_CYC = cyc(CLOCK_HOLD_AFTER_EN_LOW_PS, 5);
	localparam int CHIPSEL_SETUP_CYC = cyc(CHIPSEL_SETUP_PS, 1);
	localparam int CLOCK_VALID_BEFORE_EN_HIGH_CYC = cyc(CLOCK_VALID_BEFORE_EN_HIGH_PS, 3);
	localparam int POWERDOWN_EXIT_DELAY_CYC = cyc(POWERDOWN_EXIT_DELAY_PS, 5);
	localparam int CHIPSEL_HOLD_AFTER_EN_HIGH_CYC = cyc(CHIPSEL_HOLD_AFTER_EN_HIGH_PS, 5);
	localparam int MODEWRITE_TO_EN_LOW_HOLD_CYC = cyc(MODEWRITE_TO_EN_LOW_HOLD_PS, 10);
	localparam int CALIB_START_TO_EN_LOW_HOLD_CYC = cyc(CALIB_START_TO_EN_LOW_HOLD_PS, 3);
	localparam int MODEWRITE_CMD_PERIOD_CYC = cyc(MODEWRITE_CMD_PERIOD_PS, 10);
	localparam int MODE_SET_CMD_DELAY_CYC = cyc(MODE_SET_CMD_DELAY_PS, 10);
	localparam int EXTRA_DELAY_BEFORE_MODE_READ_CYC = cyc(ROW_TO_COL_MIN_PS, 4) + 3;
	localparam int BOOT_CLOCK_OK = (CLK_PERIOD_PS >= BOOT_CLOCK_PERIOD_MIN_PS) &&
		(CLK_PERIOD_PS <= BOOT_CLOCK_PERIOD_MAX_PS);
	localparam int TW = 5;
	typedef logic [TW-1:0] pdmr_cnt_t;
	typedef enum logic [2:0] {
		PDMR_OP_NONE = 3'h0,
		PDMR_OP_CMD = 3'h1,
		PDMR_OP_MRW = 3'h2,
		PDMR_OP_MRR = 3'h3,
		PDMR_OP_ZQ = 3'h4,
		PDMR_OP_PD_ENTER = 3'h5,
		PDMR_OP_PD_EXIT = 3'h6
	} pdmr_op_e;
	typedef struct packed {
		logic valid;
		pdmr_op_e op;
		logic [5:0] ca;
	} pdmr_req_s;
	typedef struct packed {
		logic cke;
		logic cs;
		logic clk_run;
		logic [5:0] ca;
	} pdmr_pins_s;
endpackage

// File: testbench/pdmr_ctrl_assertions.sv
`timescale 1ns/1ps
module pdmr_ctrl_assertions (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire pdmr_pkg::pdmr_req_s req,
	input wire logic boot_clock_ok,
	input wire pdmr_pkg::pdmr_pins_s pins
);
	pdmr_pkg::pdmr_op_e op_q_ff;
	logic last_mrw_ff;
	logic last_zq_ff;
	logic [4:0] hi_cnt_ff;
	logic mrw_tk;
	assign mrw_tk = pins.cs && op_q_ff == pdmr_pkg::PDMR_OP_MRW;
	// Starts saturated so only real exits count
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			op_q_ff <= pdmr_pkg::PDMR_OP_NONE;
			last_mrw_ff <= 1'b0;
			last_zq_ff <= 1'b0;
			hi_cnt_ff <= 5'h1F;
		end else begin
			op_q_ff <= req.op;
			if (pins.cs) last_mrw_ff <= mrw_tk;
			if (pins.cs) last_zq_ff <= op_q_ff == pdmr_pkg::PDMR_OP_ZQ;
			hi_cnt_ff <= !pins.cke ? 5'h00 : hi_cnt_ff + {4'h0, hi_cnt_ff != 5'h1F};
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence s_clk_10;
		pins.clk_run[*8] ##1 pins.clk_run[*2];
	endsequence
	sequence s_quiet_9;
		!pins.cs[*8] ##1 !pins.cs;
	endsequence
	a_pulse_min: assert property ($changed(pins.cke) |=> $stable(pins.cke)[*3])
		else $error("enable pulse short");
	a_cmd_to_low: assert property (pins.cs |-> pins.cke[*3])
		else $error("enable low too soon");
	a_clk_after_low: assert property ($fell(pins.cke) |-> pins.clk_run[*5])
		else $error("clock stopped early");
	a_clk_after_mrw: assert property ($fell(pins.cke) && last_mrw_ff |-> s_clk_10)
		else $error("clock stopped early after mode write");
	a_clk_after_zq: assert property ($fell(pins.cke) && last_zq_ff |-> pins.clk_run[*3])
		else $error("clock stopped early after calibration start");
	a_cs_setup: assert property ($changed(pins.cke) |-> !pins.cs && !$past(pins.cs))
		else $error("select active around enable edge");
	a_cs_after_high: assert property ($rose(pins.cke) |-> pins.cke[*5])
		else $error("enable dropped inside select hold");
	a_clk_before_high: assert property ($rose(pins.cke) |-> $past(pins.clk_run, 1) && $past(pins.clk_run, 2)
		&& $past(pins.clk_run, 3))
		else $error("clock not running before exit");
	a_exit_to_cmd: assert property ($rose(pins.cke) |-> !pins.cs[*5])
		else $error("command too soon after exit");
	a_mrw_spacing: assert property (mrw_tk |=> !mrw_tk[*8] ##1 !mrw_tk)
		else $error("mode writes too close");
	a_mrd_block: assert property (mrw_tk |=> s_quiet_9)
		else $error("command too soon after mode write");
	a_mrr_wait: assert property (pins.cs && op_q_ff == pdmr_pkg::PDMR_OP_MRR |-> hi_cnt_ff >= 5'h0C)
		else $error("mode read too soon after exit");
	a_boot_ok: assert property (!$past(sys_rst) |-> boot_clock_ok)
		else $error("boot clock flag low");
endmodule

// File: testbench/pdmr_dram_model.sv
`timescale 1ns/1ps
module pdmr_dram_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire pdmr_pkg::pdmr_pins_s pins,
	output logic rx_valid,
	output logic [5:0] rx_ca,
	output logic [7:0] viol
);
	logic [4:0] hi_cnt_ff;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_valid <= 1'b0;
			rx_ca <= 6'h00;
			viol <= 8'h00;
			hi_cnt_ff <= 5'h1F;
		end else begin
			rx_valid <= pins.cs && pins.cke && pins.clk_run;
			rx_ca <= pins.ca;
			// Whole cycles only, ns part is under one cycle here
			hi_cnt_ff <= !pins.cke ? 5'h00 : hi_cnt_ff + {4'h0, hi_cnt_ff != 5'h1F};
			if (pins.cs && (!pins.cke || hi_cnt_ff < 5'h05)) viol <= viol + 8'h01;
		end
	end
endmodule

// File: testbench/pdmr_ctrl_tb.sv
`timescale 1ns/1ps
module pdmr_ctrl_tb;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	pdmr_pkg::pdmr_req_s req = '0;
	logic req_ready, req_taken, powered_down, boot_clock_ok, rx_valid;
	pdmr_pkg::pdmr_pins_s pins;
	logic [5:0] rx_ca;
	logic [7:0] viol;
	logic [5:0] exp_q[$];
	logic cke_q = 1'b1;
	int errors = 0, n_checks = 0, cyc = 0, rise_cyc = 0, t0, t1;
	always #50 ref_clk = ~ref_clk;
	pdmr_ctrl i_pdmr_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .req_ready(req_ready),
		.req_taken(req_taken), .powered_down(powered_down), .boot_clock_ok(boot_clock_ok), .pins(pins));
	pdmr_dram_model i_pdmr_dram_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .pins(pins),
		.rx_valid(rx_valid), .rx_ca(rx_ca), .viol(viol));
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s: expected %0h, seen %0h", nm, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d, errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// One idle cycle between requests so a held valid is never taken twice
	task automatic issue(input pdmr_pkg::pdmr_op_e op, output int t);
		int n;
		n = 0;
		@(posedge ref_clk);
		#1;
		req = '{1'b1, op, 6'($urandom)};
		if (op inside {pdmr_pkg::PDMR_OP_CMD, pdmr_pkg::PDMR_OP_MRW, pdmr_pkg::PDMR_OP_MRR, pdmr_pkg::PDMR_OP_ZQ})
			exp_q.push_back(req.ca);
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (req_taken !== 1'b1 && n < 80);
		check("req_taken", req_taken, 1'b1);
		req.valid = 1'b0;
		t = cyc;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (rx_valid === 1'b1) begin
			if (exp_q.size() == 0) check("rx_extra", 1'b1, 1'b0);
			else check("rx_ca", rx_ca, exp_q.pop_front());
		end
		#1;
		if (pins.cke === 1'b1 && cke_q === 1'b0) rise_cyc = cyc;
		cke_q = pins.cke;
	end
	initial begin
		void'($urandom(83));
		repeat (20) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		check("after_reset", {req_ready, powered_down, pins.cke, pins.cs}, 4'hA);
		issue(pdmr_pkg::PDMR_OP_CMD, t0);
		issue(pdmr_pkg::PDMR_OP_ZQ, t0);
		issue(pdmr_pkg::PDMR_OP_MRR, t0);
		issue(pdmr_pkg::PDMR_OP_MRW, t0);
		issue(pdmr_pkg::PDMR_OP_MRW, t1);
		check("mrw_gap", t1 - t0 >= pdmr_pkg::MODEWRITE_CMD_PERIOD_CYC, 1'b1);
		issue(pdmr_pkg::PDMR_OP_CMD, t0);
		check("mrd_gap", t0 - t1 >= pdmr_pkg::MODE_SET_CMD_DELAY_CYC, 1'b1);
		issue(pdmr_pkg::PDMR_OP_MRW, t0);
		issue(pdmr_pkg::PDMR_OP_PD_ENTER, t0);
		repeat (20) @(posedge ref_clk);
		#1;
		check("down", {pins.cke, pins.clk_run, powered_down}, 3'b001);
		req = '{1'b1, pdmr_pkg::PDMR_OP_NONE, 6'h2A};
		repeat (5) begin
			@(posedge ref_clk);
			#1;
			check("none_taken", req_taken, 1'b0);
		end
		req.valid = 1'b0;
		issue(pdmr_pkg::PDMR_OP_PD_EXIT, t0);
		issue(pdmr_pkg::PDMR_OP_MRR, t1);
		check("mrr_gap", t1 - rise_cyc >= pdmr_pkg::POWERDOWN_EXIT_DELAY_CYC + 7, 1'b1);
		issue(pdmr_pkg::PDMR_OP_PD_ENTER, t0);
		issue(pdmr_pkg::PDMR_OP_PD_EXIT, t0);
		issue(pdmr_pkg::PDMR_OP_CMD, t1);
		check("xp_gap", t1 - rise_cyc >= pdmr_pkg::POWERDOWN_EXIT_DELAY_CYC, 1'b1);
		issue(pdmr_pkg::PDMR_OP_ZQ, t0);
		issue(pdmr_pkg::PDMR_OP_PD_ENTER, t1);
		check("zq_to_low", t1 - t0 >= pdmr_pkg::CMD_TO_CLK_EN_LOW_CYC, 1'b1);
		repeat (20) @(posedge ref_clk);
		#1;
		check("down_zq", {pins.cke, pins.clk_run, powered_down, req_ready}, 4'h3);
		issue(pdmr_pkg::PDMR_OP_PD_EXIT, t0);
		issue(pdmr_pkg::PDMR_OP_PD_ENTER, t1);
		check("csh_gap", t1 - rise_cyc >= pdmr_pkg::CHIPSEL_HOLD_AFTER_EN_HIGH_CYC, 1'b1);
		issue(pdmr_pkg::PDMR_OP_PD_EXIT, t0);
		repeat (10) @(posedge ref_clk);
		#1;
		check("awake", {pins.cke, pins.clk_run, powered_down}, 3'h6);
		check("queue_empty", exp_q.size(), 0);
		check("model_viol", viol, 8'h00);
		check("boot_ok", boot_clock_ok, 1'b1);
		finish_test();
	end
	initial begin
		#500000;
		errors++;
		finish_test();
	end
endmodule
bind pdmr_ctrl pdmr_ctrl_assertions i_pdmr_ctrl_assertions (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req),
	.boot_clock_ok(boot_clock_ok), .pins(pins));
